// File: ebl_consts.svh
// Constants for the external bus line burst and chip select block
`ifndef EBL_CONSTS_SVH
`define EBL_CONSTS_SVH

// Timing: bus clock period and system clock period in ns
`define EBL_MCLK_NS       100
`define EBL_BUS_PERIOD_NS 800

// Select control register layout
`define EBL_CTRL_W     10
`define EBL_WS_MSB     3
`define EBL_WS_LSB     0
`define EBL_AA_BIT     4
`define EBL_PW_MSB     6
`define EBL_PW_LSB     5
`define EBL_BEM_BIT    7
`define EBL_BURST_READ_ENABLE_BIT   8
`define EBL_BURST_WRITE_ENABLE_BIT   9

// Port width codes
`define EBL_PW_32      2'h0
`define EBL_PW_8       2'h1
`define EBL_PW_16      2'h2

// Boot select reset values
`define EBL_BOOT_WS    4'hF
`define EBL_BOOT_BEM   1'b1
`define EBL_BOOT_BST   2'h0
`define EBL_GLOBAL_HI  3'h0
`define EBL_STRAP_WAIT 2'h3

// Configuration write kinds
`define EBL_KIND_BASE  2'h0
`define EBL_KIND_MASK  2'h1
`define EBL_KIND_CTRL  2'h2
`define EBL_KIND_FLAGS 2'h3
`define EBL_FLAG_V     0
`define EBL_FLAG_WP    1

`endif

// File: ebl_pkg.sv
// Types for the external bus line burst and chip select block
`default_nettype none
package ebl_pkg;
    typedef enum logic [1:0] {
        ebl_idle = 2'h0,
        ebl_addr = 2'h1,
        ebl_data = 2'h3,
        ebl_end  = 2'h2
    } ebl_state_t;

    typedef struct packed {
        ebl_state_t        state;
        logic [7:0]        cnt;
        logic              clk_o;
        logic              ts_n;
        logic              as_n;
        logic              oe_n;
        logic              dq_oe_n;
        logic              rw;
        logic [2:0]        cs_n;
        logic [3:0]        bs_n;
        logic [31:0]       addr;
        logic [27:0]       line;
        logic [3:0]        off;
        logic [1:0]        start;
        logic [4:0]        beats;
        logic [3:0]        wc;
        logic [3:0]        wsc;
        logic              write;
        logic              aa;
        logic              burst;
        logic [1:0]        pw;
        logic [1:0]        sel;
        logic [127:0]      buff;
        logic [127:0]      rdata;
        logic              done;
        logic              err;
        logic [2:0][15:0]  base;
        logic [2:0][15:0]  mask;
        logic [2:0]        valid;
        logic [2:0]        wp;
        logic [2:0][9:0]   ctrl;
        logic              armed;
        logic [1:0]        strap_cnt;
    } ebl_core_t;
endpackage
`default_nettype wire

// File: ebl_sel_if.sv
// Interface between a chip select register set and its decoder
`default_nettype none
interface ebl_sel_if;
    logic [15:0] base;
    logic [15:0] mask;
    logic        valid;
    logic        wp;
    logic        enable;
    logic        global_mode;
    logic [15:0] addr_hi;
    logic        is_write;
    logic        hit;
    modport cfg   (output base, mask, valid, wp, enable, global_mode, addr_hi, is_write,
                   input hit);
    modport match (input base, mask, valid, wp, enable, global_mode, addr_hi, is_write,
                   output hit);
endinterface
`default_nettype wire

// File: ebl_sync.sv
// Two flip-flop synchroniser for pin inputs
`default_nettype none
module ebl_sync #(
    parameter int W = 1
) (
    // Clock and reset
    input  wire logic         mclk,
    input  wire logic         rst_n,
    // Data
    input  wire logic [W-1:0] d,
    output var  logic [W-1:0] q
);
    logic [W-1:0] meta;

    // First stage feeds only the second stage
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            meta <= '0;
            q    <= '0;
        end else begin
            meta <= d;
            q    <= meta;
        end
    end
endmodule
`default_nettype wire

// File: ebl_match.sv
// Address decoder for one chip select
`default_nettype none
`include "ebl_consts.svh"
module ebl_match #(
    parameter bit BOOT = 1'b0
) (
    // Select configuration and request address
    ebl_sel_if.match s
);
    // Global mode decodes a fixed 512 Mbyte region from zero and skips protection
    always_comb begin
        if (BOOT && s.global_mode) begin
            s.hit = (s.addr_hi[15:13] == `EBL_GLOBAL_HI);
        end else begin
            s.hit = s.enable && s.valid && !(s.wp && s.is_write)
                    && (((s.addr_hi ^ s.base) & ~s.mask) == 16'h0000);
        end
    end
endmodule
`default_nettype wire

// File: ebl_top.sv
// External bus line burst engine with chip select configuration
`default_nettype none
`include "ebl_consts.svh"

////////////////////////////////////////////////////////////////////////////////
// Functional notes
// - First read beat sampled at the S4 edge, second at the S6 edge.
// - Later beats take one bus clock; last read data may linger two clocks.
// - Address strobe and selected chip select stay asserted through the burst.
// - External termination holds address; internal termination advances per beat.
// - Line reads insert the select's programmed wait states per beat.
// - Write data driven one clock after start, then one beat per clock.
// - Line writes insert the select's programmed wait states per beat.
// - After reset boot select decodes from zero over 512 Mbytes.
// - Global mode ignores write protect and access qualifiers.
// - Boot select wait count resets to F, fifteen wait states.
// - Boot select byte strobe mode resets to one.
// - Boot select burst read and write enables reset to zero.
// - Boot select auto acknowledge and port width come from strap pins.
// - Secondary selects never decode until boot valid has been set.
// - Overlapping select ranges are allowed; lowest numbered select wins.
// - Configuration writes are accepted even while the valid bit is set.
// - Line is 16 aligned bytes, wrapping from the start word.
module ebl_top
    import ebl_pkg::*;
#(
    parameter int MCLK_NS   = `EBL_MCLK_NS,
    parameter int BUS_NS    = `EBL_BUS_PERIOD_NS
) (
    // Clock and reset
    input  wire logic         mclk,
    input  wire logic         rst_n,
    // Line request from the internal master
    input  wire logic         req_valid,
    output var  logic         req_ready,
    input  wire logic         req_write,
    input  wire logic [31:0]  req_addr,
    input  wire logic [127:0] req_wdata,
    output var  logic [127:0] resp_rdata,
    output var  logic         resp_done,
    output var  logic         resp_err,
    // Chip select configuration writes
    input  wire logic         cfg_we,
    input  wire logic [1:0]   cfg_sel,
    input  wire logic [1:0]   cfg_kind,
    input  wire logic [15:0]  cfg_wdata,
    output var  logic         boot_armed,
    output var  logic         burst_busy,
    // External bus pins
    output var  logic         bus_clock_out,
    output var  logic [31:0]  bus_addr,
    output var  logic         bus_rw,
    output var  logic         transfer_start_n,
    output var  logic         address_strobe_n,
    output var  logic [2:0]   chip_select_out_n,
    output var  logic [3:0]   byte_strobe_out_n,
    output var  logic         output_enable_n,
    input  wire logic         transfer_acknowledge_n,
    input  wire logic [31:0]  bus_data_in,
    output var  logic [31:0]  bus_data_out,
    output var  logic         bus_data_oe_n,
    // Boot straps
    input  wire logic [1:0]   boot_strap_pins
);
    // Half period of the bus clock in system clocks, at least one
    localparam int HALF_I = (BUS_NS / (2 * MCLK_NS)) < 1 ? 1 : BUS_NS / (2 * MCLK_NS);
    localparam logic [7:0] HALF = 8'(HALF_I);
    localparam logic [7:0] LAST = 8'(2 * HALF_I - 1);
    // One bus clock in system clocks, for the beat timing check
    localparam int BEAT_GAP = 2 * HALF_I;

    ebl_core_t    r;
    ebl_core_t    next_r;
    logic [34:0]  pin_s;
    logic [31:0]  data_s;
    logic         ta_s;
    logic [1:0]   strap_s;
    logic         rise;
    logic         fall;
    logic [2:0]   hit;
    logic [1:0]   hsel;
    logic [9:0]   hc;
    logic         ack;
    logic [4:0]   bytes;

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers: TA, data and straps all come from outside
    ebl_sync #(.W(35)) u_sync (
        .mclk  (mclk),
        .rst_n (rst_n),
        .d     ({transfer_acknowledge_n, boot_strap_pins, bus_data_in}),
        .q     (pin_s)
    );
    assign ta_s    = !pin_s[34];
    assign strap_s = pin_s[33:32];
    assign data_s  = pin_s[31:0];

    ////////////////////////////////////////////////////////////////////////////
    // Chip select decoders; lowest index wins on overlap
    ebl_sel_if sif[3] ();
    for (genvar i = 0; i < 3; i++) begin : g_sel
        assign sif[i].base        = r.base[i];
        assign sif[i].mask        = r.mask[i];
        assign sif[i].valid       = r.valid[i];
        assign sif[i].wp          = r.wp[i];
        assign sif[i].enable      = (i == 0) || r.armed;
        assign sif[i].global_mode = !r.armed;
        assign sif[i].addr_hi     = req_addr[31:16];
        assign sif[i].is_write    = req_write;
        assign hit[i]             = sif[i].hit;
        ebl_match #(.BOOT(i == 0)) u_match (
            .s (sif[i].match)
        );
    end

    // Overlaps are not refused, a fixed priority picks one
    assign hsel = hit[0] ? 2'h0 : (hit[1] ? 2'h1 : 2'h2);
    assign hc   = r.ctrl[hsel];

    ////////////////////////////////////////////////////////////////////////////
    // Bus clock phases and acknowledge source
    assign rise  = (r.cnt == LAST);
    assign fall  = (r.cnt == HALF - 8'h01);
    assign ack   = r.aa ? (r.wc == 4'h0) : ta_s;
    assign bytes = (r.pw == `EBL_PW_32) ? 5'h04 : ((r.pw == `EBL_PW_8) ? 5'h01 : 5'h02);
    assign req_ready = (r.state == ebl_idle) && rise;

    // Next state of the whole block
    always_comb begin
        next_r      = r;
        next_r.done = 1'b0;
        next_r.err  = 1'b0;
        next_r.cnt  = rise ? 8'h00 : r.cnt + 8'h01;
        if (rise) begin
            next_r.clk_o = 1'b1;
        end else if (fall) begin
            next_r.clk_o = 1'b0;
        end
        // Straps are re-read until the synchroniser has settled
        if (r.strap_cnt != 2'h0) begin
            next_r.strap_cnt                        = r.strap_cnt - 2'h1;
            next_r.ctrl[0][`EBL_AA_BIT]             = strap_s[1];
            next_r.ctrl[0][`EBL_PW_MSB:`EBL_PW_LSB] = strap_s[0] ? `EBL_PW_16 : `EBL_PW_32;
        end
        // Configuration writes land whatever the valid bit says
        if (cfg_we && cfg_sel != 2'h3) begin
            case (cfg_kind)
                `EBL_KIND_BASE: next_r.base[cfg_sel] = cfg_wdata;
                `EBL_KIND_MASK: next_r.mask[cfg_sel] = cfg_wdata;
                `EBL_KIND_CTRL: next_r.ctrl[cfg_sel] = cfg_wdata[`EBL_CTRL_W-1:0];
                default: begin
                    next_r.valid[cfg_sel] = cfg_wdata[`EBL_FLAG_V];
                    next_r.wp[cfg_sel]    = cfg_wdata[`EBL_FLAG_WP];
                    if (cfg_sel == 2'h0 && cfg_wdata[`EBL_FLAG_V]) begin
                        next_r.armed = 1'b1;
                    end
                end
            endcase
        end
        case (r.state)
            ebl_idle: begin
                if (req_valid && rise) begin
                    if (hit == 3'h0) begin
                        next_r.err = 1'b1;
                    end else begin
                        next_r.state = ebl_addr;
                        next_r.sel   = hsel;
                        next_r.write = req_write;
                        next_r.aa    = hc[`EBL_AA_BIT];
                        next_r.pw    = hc[`EBL_PW_MSB:`EBL_PW_LSB];
                        next_r.wsc   = hc[`EBL_WS_MSB:`EBL_WS_LSB];
                        next_r.burst = req_write ? hc[`EBL_BURST_WRITE_ENABLE_BIT] : hc[`EBL_BURST_READ_ENABLE_BIT];
                        next_r.bs_n  = (hc[`EBL_BEM_BIT] || req_write) ? 4'h0 : 4'hF;
                        next_r.line  = req_addr[31:4];
                        next_r.start = req_addr[3:2];
                        next_r.off   = {req_addr[3:2], 2'h0};
                        next_r.addr  = {req_addr[31:2], 2'h0};
                        next_r.beats = (hc[`EBL_PW_MSB:`EBL_PW_LSB] == `EBL_PW_32) ? 5'h04 :
                                       ((hc[`EBL_PW_MSB:`EBL_PW_LSB] == `EBL_PW_8) ? 5'h10
                                                                                  : 5'h08);
                        // Rotate so the start word leaves first
                        next_r.buff  = 128'({req_wdata, req_wdata} >> {req_addr[3:2], 5'h00});
                        next_r.rw    = !req_write;
                        next_r.ts_n  = 1'b0;
                    end
                end
            end
            ebl_addr: begin
                if (fall) begin
                    next_r.as_n = 1'b0;
                    next_r.cs_n = ~(3'h1 << r.sel);
                    next_r.oe_n = r.write;
                end
                if (rise) begin
                    next_r.ts_n  = 1'b1;
                    next_r.state = ebl_data;
                    next_r.wc    = r.wsc;
                    if (r.write) begin
                        next_r.dq_oe_n = 1'b0;
                    end
                end
            end
            ebl_data: begin
                if (rise) begin
                    if (!ack) begin
                        next_r.wc = r.wc - 4'h1;
                    end else begin
                        // Beat taken: one bus clock each once acknowledged
                        if (r.write) begin
                            next_r.buff = r.buff >> {bytes, 3'h0};
                        end else if (r.pw == `EBL_PW_32) begin
                            next_r.buff = {data_s, r.buff[127:32]};
                        end else if (r.pw == `EBL_PW_8) begin
                            next_r.buff = {data_s[7:0], r.buff[127:8]};
                        end else begin
                            next_r.buff = {data_s[15:0], r.buff[127:16]};
                        end
                        next_r.beats = r.beats - 5'h01;
                        next_r.wc    = r.wsc;
                        next_r.off   = r.off + bytes[3:0];
                        if (r.aa && r.burst) begin
                            next_r.addr = {r.line, r.off + bytes[3:0]};
                        end
                        if (r.beats == 5'h01 || !r.burst) begin
                            next_r.state = ebl_end;
                        end
                    end
                end
            end
            ebl_end: begin
                if (fall) begin
                    next_r.as_n = 1'b1;
                    next_r.cs_n = 3'h7;
                    next_r.oe_n = 1'b1;
                    next_r.bs_n = 4'hF; // Byte strobes drop with the selects
                end
                if (rise) begin
                    next_r.dq_oe_n = 1'b1;
                    if (r.beats != 5'h00) begin
                        // Burst-inhibited line: a fresh basic cycle per beat
                        next_r.state = ebl_addr;
                        next_r.ts_n  = 1'b0;
                        next_r.bs_n  = (r.ctrl[r.sel][`EBL_BEM_BIT] || r.write) ? 4'h0 : 4'hF;
                        if (r.aa) begin
                            next_r.addr = {r.line, r.off};
                        end
                    end else begin
                        next_r.state = ebl_idle;
                        next_r.done  = 1'b1;
                        next_r.addr  = {r.line, r.start, 2'h0};
                        next_r.rdata = 128'({r.buff, r.buff} >> {~r.start + 2'h1, 5'h00});
                    end
                end
            end
            default: next_r.state = ebl_idle;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // State register; boot select comes up in global mode
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            r                                     <= '0;
            r.ts_n                                <= 1'b1;
            r.as_n                                <= 1'b1;
            r.oe_n                                <= 1'b1;
            r.dq_oe_n                             <= 1'b1;
            r.rw                                  <= 1'b1;
            r.cs_n                                <= 3'h7;
            r.bs_n                                <= 4'hF;
            r.ctrl[0][`EBL_WS_MSB:`EBL_WS_LSB]    <= `EBL_BOOT_WS;
            r.ctrl[0][`EBL_BEM_BIT]               <= `EBL_BOOT_BEM;
            r.ctrl[0][`EBL_BURST_WRITE_ENABLE_BIT:`EBL_BURST_READ_ENABLE_BIT] <= `EBL_BOOT_BST;
            r.strap_cnt                           <= `EBL_STRAP_WAIT;
        end else begin
            r <= next_r;
        end
    end

    // Pin and status outputs straight from the state
    assign bus_clock_out     = r.clk_o;
    assign bus_addr          = r.addr;
    assign bus_rw            = r.rw;
    assign transfer_start_n  = r.ts_n;
    assign address_strobe_n  = r.as_n;
    assign chip_select_out_n = r.cs_n;
    assign byte_strobe_out_n = r.bs_n;
    assign output_enable_n   = r.oe_n;
    assign bus_data_out      = r.buff[31:0];
    assign bus_data_oe_n     = r.dq_oe_n;
    assign resp_rdata        = r.rdata;
    assign resp_done         = r.done;
    assign resp_err          = r.err;
    assign boot_armed        = r.armed;
    assign burst_busy        = (r.state != ebl_idle);

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    a_strobe_hold: assert property (r.state == ebl_data |-> !r.as_n && r.cs_n != 3'h7)
        else $error("strobes dropped inside a burst");
    a_ext_addr_hold: assert property ((r.state == ebl_data && !r.aa) |=> $stable(r.addr))
        else $error("address moved under external termination");
    a_wait_insert: assert property ((rise && r.state == ebl_data && r.aa && r.wc != 4'h0)
        |=> r.beats == $past(r.beats))
        else $error("beat taken during a wait state");
    a_boot_reset: assert property ($past(!rst_n) |-> r.ctrl[0][`EBL_WS_MSB:`EBL_WS_LSB] == 4'hF
        && r.ctrl[0][`EBL_BEM_BIT] && r.ctrl[0][`EBL_BURST_WRITE_ENABLE_BIT:`EBL_BURST_READ_ENABLE_BIT] == 2'h0)
        else $error("boot select reset values wrong");
    a_global_decode: assert property ((!r.armed && req_addr[31:29] == 3'h0) |-> hit[0])
        else $error("global boot decode missed");
    a_second_gate: assert property (!r.armed |-> hit[2:1] == 2'h0)
        else $error("secondary select decoded before arming");
    a_cfg_accept: assert property ((cfg_we && cfg_kind == `EBL_KIND_CTRL && cfg_sel == 2'h1)
        |=> r.ctrl[1] == $past(cfg_wdata[9:0]))
        else $error("configuration write lost");
    a_zero_wait: assert property ((rise && r.state == ebl_addr && r.aa && r.wsc == 4'h0
        && r.burst) |=> r.state == ebl_data ##BEAT_GAP r.beats == $past(r.beats) - 5'h01)
        else $error("first beat not at second bus clock");
    a_write_drive: assert property ((r.state == ebl_data && r.write) |-> !r.dq_oe_n)
        else $error("write data not driven in burst");
    a_line_wrap: assert property ((r.state != ebl_idle && r.pw == `EBL_PW_32)
        |-> r.off[1:0] == 2'h0 && r.addr[31:4] == r.line)
        else $error("line address left its line");
endmodule
`default_nettype wire

// File: ebl_mem_model.sv
// Behavioural model of the external memory on the line burst pins
`default_nettype none
module ebl_mem_model (
    // Bus pins from the interface
    input  wire logic        bus_clock_out,
    input  wire logic [31:0] bus_addr,
    input  wire logic        bus_rw,
    input  wire logic [2:0]  chip_select_out_n,
    input  wire logic [31:0] bus_data_out,
    // Extra bus clocks before each acknowledge
    input  wire logic [3:0]  wait_cycles,
    // Responses to the interface
    output var  logic        transfer_acknowledge_n,
    output var  logic [31:0] bus_data_in
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [31:0] mem [4];
    logic [3:0]  held;
    logic [31:0] ack_addr;
    logic [1:0]  prev;
    logic [1:0]  word;
    // A moving address names the word; a held one means the next word of the line
    assign word = (bus_addr == ack_addr) ? prev + 2'h1 : bus_addr[3:2];
    initial begin
        for (int i = 0; i < 4; i++) mem[i] = 32'hA5A50000 + 32'(i);
        held = 4'h0;
        ack_addr = 32'hFFFFFFFF;
        prev = 2'h0;
        transfer_acknowledge_n = 1'b1;
        bus_data_in = 32'h0;
    end
    // Pins move on the falling bus clock, leaving the sync stages time before the rise
    always @(negedge bus_clock_out) begin
        // Look just after the edge, once strobes launched with it have settled
        #1;
        if (chip_select_out_n == 3'h7 || held < wait_cycles + 4'h1) begin
            held <= (chip_select_out_n == 3'h7) ? 4'h0 : held + 4'h1;
            transfer_acknowledge_n <= 1'b1;
            bus_data_in <= ~bus_data_in; // Released bus toggles each clock between the last word and its inverse
        end else begin
            // Acknowledge wait_cycles plus one clocks after select, never fast: inhibited lines see basic cycles
            transfer_acknowledge_n <= 1'b0;
            bus_data_in <= mem[word];
            if (!bus_rw) mem[word] <= bus_data_out;
            ack_addr <= bus_addr;
            prev <= word;
            held <= 4'h1;
        end
    end
endmodule
`default_nettype wire

// File: ebl_top_test.sv
// Self-checking bench for the line burst and chip select block
`default_nettype none
module ebl_top_test;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [127:0] INIT = 128'hA5A50003A5A50002A5A50001A5A50000;
    localparam logic [127:0] W1   = 128'h33330003222200021111000100000000;
    localparam logic [127:0] W2   = 128'hDDDD0003CCCC0002BBBB0001AAAA0000;
    logic mclk, rst_n, req_valid, req_ready, req_write, resp_done, resp_err, cfg_we;
    logic boot_armed, burst_busy, bus_clock_out, bus_rw, ts_n, as_n, oe_n, ta_n, dq_oe_n;
    logic [1:0] cfg_sel, cfg_kind, straps;
    logic [2:0] cs_n, cs_seen, last_cs;
    logic [3:0] bs_n, wait_cycles, bs_seen;
    logic [15:0] cfg_wdata;
    logic [31:0] req_addr, bus_addr, din, dout;
    logic [127:0] req_wdata, resp_rdata;
    logic last_as;
    int err_total, comparisons, cs_starts, as_starts;

    ebl_top u_dut (.mclk(mclk), .rst_n(rst_n), .req_valid(req_valid), .req_ready(req_ready),
        .req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata),
        .resp_rdata(resp_rdata), .resp_done(resp_done), .resp_err(resp_err), .cfg_we(cfg_we),
        .cfg_sel(cfg_sel), .cfg_kind(cfg_kind), .cfg_wdata(cfg_wdata),
        .boot_armed(boot_armed), .burst_busy(burst_busy), .bus_clock_out(bus_clock_out),
        .bus_addr(bus_addr), .bus_rw(bus_rw), .transfer_start_n(ts_n),
        .address_strobe_n(as_n), .chip_select_out_n(cs_n), .byte_strobe_out_n(bs_n),
        .output_enable_n(oe_n), .transfer_acknowledge_n(ta_n), .bus_data_in(din),
        .bus_data_out(dout), .bus_data_oe_n(dq_oe_n), .boot_strap_pins(straps));
    ebl_mem_model u_mem (.bus_clock_out(bus_clock_out), .bus_addr(bus_addr), .bus_rw(bus_rw),
        .chip_select_out_n(cs_n), .bus_data_out(dout), .wait_cycles(wait_cycles),
        .transfer_acknowledge_n(ta_n), .bus_data_in(din));

    ////////////////////////////////////////////////////////////////////////////
    // Clock and strobe monitor: counting select starts tells bursts from basic cycles
    always #50 mclk = ~mclk;
    always @(posedge mclk) begin
        if (cs_n != 3'h7 && last_cs == 3'h7) cs_starts++;
        if (!as_n && last_as) as_starts++;
        if (cs_n != 3'h7) cs_seen = cs_n;
        if (!as_n) bs_seen = bs_n;
        last_cs = cs_n;
        last_as = as_n;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Comparison, verdict and access tasks
    task automatic check(input string what, input logic [127:0] seen, input logic [127:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic test_done;
        $display("Comparisons %0d mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic cfg(input logic [1:0] s, input logic [1:0] k, input logic [15:0] d);
        cfg_sel = s;
        cfg_kind = k;
        cfg_wdata = d;
        cfg_we = 1'b1;
        @(posedge mclk);
        #10;
        cfg_we = 1'b0;
        @(posedge mclk);
        #10;
    endtask
    // One line request; expected data, error and number of select starts given
    task automatic run(input logic wr, input logic [31:0] a, input logic [127:0] d,
                       input logic er, input int starts);
        int n;
        n = 0;
        cs_starts = 0;
        as_starts = 0;
        bs_seen = 4'hF;
        req_write = wr;
        req_addr = a;
        req_wdata = d;
        req_valid = 1'b1;
        while (req_ready !== 1'b1 && n < 600) begin
            @(posedge mclk);
            #10;
            n++;
        end
        @(posedge mclk);
        #10;
        req_valid = 1'b0;
        while (resp_done !== 1'b1 && resp_err !== 1'b1 && n < 600) begin
            @(posedge mclk);
            #10;
            n++;
        end
        if (n >= 600) begin
            err_total++;
            $display("CHECK FAILED line at %h expected done seen timeout", a);
            test_done();
        end
        check("resp_err", 128'(resp_err), 128'(er));
        if (!wr && !er) check("resp_rdata", resp_rdata, d);
        repeat (2) @(posedge mclk);
        #10;
        check("cs_starts", 128'(cs_starts), 128'(starts));
        check("as_starts", 128'(as_starts), 128'(starts));
        if (!er) check("bs_seen", 128'(bs_seen), 128'h0);
        check("bs idle", 128'(bs_n), 128'hF);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        {mclk, req_valid, req_write, cfg_we, rst_n} = 5'h00;
        {cfg_sel, cfg_kind, cfg_wdata, req_addr, req_wdata} = '0;
        {straps, wait_cycles, cs_seen, last_cs, last_as} = {2'h0, 4'h0, 3'h7, 3'h7, 1'b1};
        repeat (10) @(posedge mclk);
        #10;
        rst_n = 1'b1;
        repeat (4) @(posedge mclk);
        #10;
        check("cs idle", 128'(cs_n), 128'h7);
        check("boot_armed", 128'(boot_armed), 128'h0);
        run(1'b0, 32'h00000008, INIT, 1'b0, 4);
        run(1'b0, 32'h1FFFFFF0, INIT, 1'b0, 4);
        run(1'b0, 32'h20000000, INIT, 1'b1, 0);
        cfg(2'h0, 2'h3, 16'h0002);
        run(1'b1, 32'h0000000C, W1, 1'b0, 4);
        run(1'b0, 32'h00000004, W1, 1'b0, 4);
        // Secondary first, then boot with valid clear, then valid set to arm, then valid clear again
        cfg(2'h1, 2'h0, 16'h4000);
        cfg(2'h1, 2'h2, 16'h0380);
        cfg(2'h1, 2'h1, 16'h00FF);
        cfg(2'h1, 2'h3, 16'h0001);
        run(1'b0, 32'h40000000, W1, 1'b1, 0);
        cfg(2'h0, 2'h0, 16'h0000);
        cfg(2'h0, 2'h2, 16'h0380);
        cfg(2'h0, 2'h1, 16'h1FFF);
        cfg(2'h0, 2'h3, 16'h0000);
        cfg(2'h0, 2'h3, 16'h0001);
        cfg(2'h0, 2'h3, 16'h0000);
        check("boot_armed", 128'(boot_armed), 128'h1);
        wait_cycles = 4'h2;
        run(1'b1, 32'h40000008, W2, 1'b0, 1);
        check("cs_seen", 128'(cs_seen), 128'h5);
        run(1'b0, 32'h40000000, W2, 1'b0, 1);
        wait_cycles = 4'h0;
        cfg(2'h1, 2'h0, 16'h6000);
        run(1'b0, 32'h60000004, W2, 1'b0, 1);
        run(1'b0, 32'h40000000, W2, 1'b1, 0);
        cfg(2'h1, 2'h3, 16'h0000);
        cfg(2'h1, 2'h0, 16'h4000);
        cfg(2'h1, 2'h3, 16'h0001);
        run(1'b0, 32'h4000000C, W2, 1'b0, 1);
        // Internal termination: address steps per beat, programmed waits per beat
        cfg(2'h1, 2'h2, 16'h0390);
        run(1'b0, 32'h4000000C, W2, 1'b0, 1);
        cfg(2'h1, 2'h2, 16'h0392);
        wait_cycles = 4'h2;
        run(1'b0, 32'h40000004, W2, 1'b0, 1);
        test_done();
    end
endmodule
`default_nettype wire
